// File: qcr_pkg.sv
// Package: constants and carrier types for the quadrature correction register block.
// Assumes byte-wide registers placed one per aligned 32-bit APB word.
package qcr_pkg;
	localparam logic [11:0] ADDR_GAIN_A_LOW   = 12'h00c;
	localparam logic [11:0] ADDR_GAIN_B_LOW   = 12'h00d;
	localparam logic [11:0] ADDR_PHASE_LOW    = 12'h00e;
	localparam logic [11:0] ADDR_UPPER_BITS   = 12'h00f;
	localparam logic [11:0] ADDR_OFFSET_A_LOW = 12'h010;
	localparam logic [11:0] ADDR_OFFSET_B_LOW = 12'h011;
	localparam logic [11:0] ADDR_OFFSET_A_HI  = 12'h012;
	localparam logic [11:0] ADDR_OFFSET_B_HI  = 12'h013;
	localparam logic [11:0] ADDR_CONST_LOW    = 12'h014;
	localparam logic [11:0] ADDR_CONST_HIGH   = 12'h015;
	localparam logic [11:0] ADDR_SYNC_CTRL    = 12'h016;
	localparam logic [11:0] ADDR_CONTROL      = 12'h017;
	localparam logic [11:0] ADDR_STATUS       = 12'h018;
	localparam logic [7:0]  RST_ZERO          = 8'h00;
	localparam logic [7:0]  RST_UPPER_BITS    = 8'h24;
	localparam logic [7:0]  RST_SYNC_CTRL     = 8'h05;
	localparam int          UB_PHASE_POS      = 6;
	localparam int          UB_GAIN_A_POS     = 3;
	localparam int          UB_GAIN_B_POS     = 0;
	localparam int          OFS_HI_POS        = 3;
	localparam int          SEL_CORR_POS      = 2;
	localparam int          SEL_OFS_POS       = 0;
	localparam int          CTL_CONST_EN_POS  = 0;
	localparam int          CTL_STROBE_POS    = 1;
	localparam int          GAIN_FRAC_BITS    = 10;
	localparam int          PHASE_SHIFT       = 12;
	localparam int          PIPE_LATENCY      = 2;

	typedef enum logic [1:0] {
		QCR_SYNC_GATE   = 2'b00,
		QCR_SYNC_ALIGN  = 2'b01,
		QCR_SYNC_HOST   = 2'b10,
		QCR_SYNC_NEVER  = 2'b11
	} qcr_sync_sel_t;

	typedef struct packed {
		logic [10:0] gain_a;
		logic [10:0] gain_b;
		logic [9:0]  phase;
	} qcr_corr_t;

	typedef struct packed {
		logic [12:0] offset_a;
		logic [12:0] offset_b;
	} qcr_offs_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] i_data;
		logic [15:0] q_data;
	} qcr_sample_t;
endpackage

// File: qcr_sync_pick.sv
// Sync source selector, one per shadow register group.
// Assumes all sync inputs are one-cycle pulses on pclk.
`timescale 1ns/100ps
`default_nettype none
module qcr_sync_pick
	import qcr_pkg::*;
(
	input  wire logic          gate_sync,
	input  wire logic          align_sync,
	input  wire logic          host_sync,
	input  wire qcr_sync_sel_t sel,
	output logic               fire
);
	always_comb begin
		case (sel)
			QCR_SYNC_GATE:  fire = gate_sync;
			QCR_SYNC_ALIGN: fire = align_sync;
			QCR_SYNC_HOST:  fire = host_sync;
			default:        fire = 1'b0;
		endcase
	end
endmodule // qcr_sync_pick
`default_nettype wire

// File: qcr_regs.sv
// Quadrature correction registers and datapath with APB slave.
// Assumes gate and align strobes come from pclk-domain FIFO logic.
`timescale 1ns/100ps
`default_nettype none
module qcr_regs
	import qcr_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        transmit_gate,
	input  wire logic        align_strobe,
	input  wire qcr_pkg::qcr_sample_t sample_in,
	output qcr_pkg::qcr_sample_t      converter_out
);
	import qcr_pkg::*;

	logic [7:0]    gain_a_low;
	logic [7:0]    gain_b_low;
	logic [7:0]    phase_skew_low;
	logic [7:0]    correction_upper_bits;
	logic [7:0]    offset_a_low;
	logic [7:0]    offset_b_low;
	logic [7:0]    offset_a_high;
	logic [7:0]    offset_b_high;
	logic [7:0]    constant_sample_low;
	logic [7:0]    constant_sample_high;
	logic [7:0]    sync_ctrl;
	logic          const_en;
	logic          host_written_strobe;
	logic          corr_seen;
	logic          offs_seen;
	qcr_corr_t     corr_act;
	qcr_offs_t     offs_act;
	logic          corr_fire;
	logic          offs_fire;
	logic          wr_en;
	logic          wr_take;
	logic [9:0]    wr_idx;
	logic          rd_en;
	logic          addr_ok;
	logic [7:0]    rd_byte;
	qcr_sample_t   stage1;
	logic signed [28:0] prod_a;
	logic signed [28:0] prod_b;
	logic signed [27:0] prod_ph;
	logic signed [18:0] sum_a;
	logic signed [18:0] sum_b;
	logic signed [16:0] ph_term;
	logic signed [16:0] q_term;
	logic signed [18:0] next_a;
	logic signed [18:0] next_b;

	function automatic logic [15:0] sat16(input logic signed [18:0] v);
		if (v > 19'sd32767)
			sat16 = 16'h7fff;
		else if (v < -19'sd32768)
			sat16 = 16'h8000;
		else
			sat16 = v[15:0];
	endfunction

	// APB decode, zero-wait answer
	assign wr_en = psel && penable && pwrite && pstrb[0];
	assign rd_en = psel && penable && !pwrite;
	assign wr_take = wr_en && pready && addr_ok;
	assign wr_idx = paddr[11:2];
	assign addr_ok = (paddr[1:0] == 2'b00) &&
		(paddr[11:2] >= ADDR_GAIN_A_LOW[9:0]) && (paddr[11:2] <= ADDR_STATUS[9:0]);

	always_comb begin
		case (paddr[11:2])
			ADDR_GAIN_A_LOW[9:0]:   rd_byte = gain_a_low;
			ADDR_GAIN_B_LOW[9:0]:   rd_byte = gain_b_low;
			ADDR_PHASE_LOW[9:0]:    rd_byte = phase_skew_low;
			ADDR_UPPER_BITS[9:0]:   rd_byte = correction_upper_bits;
			ADDR_OFFSET_A_LOW[9:0]: rd_byte = offset_a_low;
			ADDR_OFFSET_B_LOW[9:0]: rd_byte = offset_b_low;
			ADDR_OFFSET_A_HI[9:0]:  rd_byte = {offset_a_high[7:3], 3'h0};
			ADDR_OFFSET_B_HI[9:0]:  rd_byte = {offset_b_high[7:3], 3'h0};
			ADDR_CONST_LOW[9:0]:    rd_byte = constant_sample_low;
			ADDR_CONST_HIGH[9:0]:   rd_byte = constant_sample_high;
			ADDR_SYNC_CTRL[9:0]:    rd_byte = {4'h0, sync_ctrl[3:0]};
			ADDR_CONTROL[9:0]:      rd_byte = {7'h00, const_en};
			ADDR_STATUS[9:0]:       rd_byte = {6'h00, offs_seen, corr_seen};
			default:                rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (psel && !penable && !pwrite && addr_ok)
				prdata <= {24'h00_0000, rd_byte};
			else if (psel && !penable)
				prdata <= 32'h0000_0000;
		end
	end

	// Gain A low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gain_a_low <= RST_ZERO;
		else if (wr_take && wr_idx == ADDR_GAIN_A_LOW[9:0])
			gain_a_low <= pwdata[7:0];
	end

	// Gain B low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gain_b_low <= RST_ZERO;
		else if (wr_take && wr_idx == ADDR_GAIN_B_LOW[9:0])
			gain_b_low <= pwdata[7:0];
	end

	// Phase low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase_skew_low <= RST_ZERO;
		else if (wr_take && wr_idx == ADDR_PHASE_LOW[9:0])
			phase_skew_low <= pwdata[7:0];
	end

	// Shared upper bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			correction_upper_bits <= RST_UPPER_BITS;
		else if (wr_take && wr_idx == ADDR_UPPER_BITS[9:0])
			correction_upper_bits <= pwdata[7:0];
	end

	// Offset A low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			offset_a_low <= RST_ZERO;
		else if (wr_take && wr_idx == ADDR_OFFSET_A_LOW[9:0])
			offset_a_low <= pwdata[7:0];
	end

	// Offset B low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			offset_b_low <= RST_ZERO;
		else if (wr_take && wr_idx == ADDR_OFFSET_B_LOW[9:0])
			offset_b_low <= pwdata[7:0];
	end

	// Offset A upper bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			offset_a_high <= RST_ZERO;
		else if (wr_take && wr_idx == ADDR_OFFSET_A_HI[9:0])
			offset_a_high <= {pwdata[7:3], 3'h0};
	end

	// Offset B upper bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			offset_b_high <= RST_ZERO;
		else if (wr_take && wr_idx == ADDR_OFFSET_B_HI[9:0])
			offset_b_high <= {pwdata[7:3], 3'h0};
	end

	// Constant sample low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			constant_sample_low <= RST_ZERO;
		else if (wr_take && wr_idx == ADDR_CONST_LOW[9:0])
			constant_sample_low <= pwdata[7:0];
	end

	// Constant sample high byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			constant_sample_high <= RST_ZERO;
		else if (wr_take && wr_idx == ADDR_CONST_HIGH[9:0])
			constant_sample_high <= pwdata[7:0];
	end

	// Sync source selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sync_ctrl <= RST_SYNC_CTRL;
		else if (wr_take && wr_idx == ADDR_SYNC_CTRL[9:0])
			sync_ctrl <= {4'h0, pwdata[3:0]};
	end

	// Constant enable level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			const_en <= 1'b0;
		else if (wr_take && wr_idx == ADDR_CONTROL[9:0])
			const_en <= pwdata[CTL_CONST_EN_POS];
	end

	// Self-clearing host strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			host_written_strobe <= 1'b0;
		else
			host_written_strobe <= wr_en && pready && (paddr[11:2] == ADDR_CONTROL[9:0])
				&& pwdata[CTL_STROBE_POS];
	end

	qcr_sync_pick u_corr_pick (
		.gate_sync  (transmit_gate),
		.align_sync (align_strobe),
		.host_sync  (host_written_strobe),
		.sel        (qcr_sync_sel_t'(sync_ctrl[SEL_CORR_POS +: 2])),
		.fire       (corr_fire)
	);

	qcr_sync_pick u_offs_pick (
		.gate_sync  (transmit_gate),
		.align_sync (align_strobe),
		.host_sync  (host_written_strobe),
		.sel        (qcr_sync_sel_t'(sync_ctrl[SEL_OFS_POS +: 2])),
		.fire       (offs_fire)
	);

	// Active copies loaded only on sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			corr_act.gain_a <= {RST_UPPER_BITS[UB_GAIN_A_POS +: 3], RST_ZERO};
			corr_act.gain_b <= {RST_UPPER_BITS[UB_GAIN_B_POS +: 3], RST_ZERO};
			corr_act.phase  <= {RST_UPPER_BITS[UB_PHASE_POS +: 2], RST_ZERO};
		end else if (corr_fire) begin
			corr_act.gain_a <= {correction_upper_bits[UB_GAIN_A_POS +: 3], gain_a_low};
			corr_act.gain_b <= {correction_upper_bits[UB_GAIN_B_POS +: 3], gain_b_low};
			corr_act.phase  <= {correction_upper_bits[UB_PHASE_POS +: 2], phase_skew_low};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offs_act <= '0;
		end else if (offs_fire) begin
			offs_act.offset_a <= {offset_a_high[OFS_HI_POS +: 5], offset_a_low};
			offs_act.offset_b <= {offset_b_high[OFS_HI_POS +: 5], offset_b_low};
		end
	end

	// Sticky sync-seen status, cleared by a status write with pstrb[0] set; a sync firing in the same cycle wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			corr_seen <= 1'b0;
			offs_seen <= 1'b0;
		end else begin
			if (corr_fire)
				corr_seen <= 1'b1;
			else if (wr_en && pready && paddr[11:2] == ADDR_STATUS[9:0])
				corr_seen <= 1'b0;
			if (offs_fire)
				offs_seen <= 1'b1;
			else if (wr_en && pready && paddr[11:2] == ADDR_STATUS[9:0])
				offs_seen <= 1'b0;
		end
	end

	// Datapath stage 1: gain and phase
	assign prod_a  = $signed(sample_in.i_data) * $signed({2'b00, corr_act.gain_a});
	assign prod_b  = $signed(sample_in.q_data) * $signed({2'b00, corr_act.gain_b});
	assign prod_ph = $signed(sample_in.q_data) * $signed(corr_act.phase);
	assign ph_term = 17'(prod_ph >>> PHASE_SHIFT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
		end else begin
			stage1.valid  <= sample_in.valid;
			stage1.i_data <= sat16(19'(prod_a >>> GAIN_FRAC_BITS)
				+ 19'(ph_term));
			stage1.q_data <= sat16(19'(prod_b >>> GAIN_FRAC_BITS));
		end
	end

	// Datapath stage 2: offset, saturate, constant override
	assign q_term = 17'(signed'(stage1.q_data));
	assign sum_a  = 19'(signed'(stage1.i_data)) + 19'(signed'(offs_act.offset_a));
	assign sum_b  = 19'(q_term) + 19'(signed'(offs_act.offset_b));
	assign next_a = sum_a;
	assign next_b = sum_b;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_out <= '0;
		end else if (const_en) begin
			converter_out.valid  <= stage1.valid;
			converter_out.i_data <= {constant_sample_high, constant_sample_low};
			converter_out.q_data <= {constant_sample_high, constant_sample_low};
		end else begin
			converter_out.valid  <= stage1.valid;
			converter_out.i_data <= sat16(next_a);
			converter_out.q_data <= sat16(next_b);
		end
	end
endmodule // qcr_regs
`default_nettype wire

// File: qcr_regs_sva.sv
// Checker: APB answer timing and sample pipeline of the correction registers.
// Assumes it is bound to every qcr_regs instance.
`timescale 1ns/100ps
`default_nettype none
module qcr_regs_sva
	import qcr_pkg::*;
(
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire qcr_pkg::qcr_sample_t sample_in,
	input wire qcr_pkg::qcr_sample_t converter_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	rdy_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	rdy_one_cycle_a: assert property (pready |=> !pready) else $error("pready too long");
	idle_no_rdy_a: assert property (!psel |=> !pready) else $error("pready without request");
	err_with_rdy_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
		else $error("misaligned access accepted");
	low_addr_err_a: assert property (psel && !penable && paddr[11:2] < 10'h00c |=> pslverr)
		else $error("unmapped access accepted");
	err_zero_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
	byte_only_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	valid_pipe_a: assert property ($past(presetn, 2) |->
		converter_out.valid == $past(sample_in.valid, 2)) else $error("valid delay wrong");
endmodule // qcr_regs_sva
bind qcr_regs qcr_regs_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sample_in(sample_in), .converter_out(converter_out));
`default_nettype wire

// File: qcr_src.sv
// Upstream sample source and FIFO sync pulses.
// Assumes requests are driven just after a pclk edge.
`timescale 1ns/100ps
`default_nettype none
module qcr_src
	import qcr_pkg::*;
(
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic [15:0]     i_set,
	input  wire logic [15:0]     q_set,
	input  wire logic            gate_req,
	input  wire logic            align_req,
	output var qcr_pkg::qcr_sample_t sample,
	output logic                 gate,
	output logic                 align
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample <= '0;
			gate <= 1'b0;
			align <= 1'b0;
		end else begin
			sample <= '{1'b1, i_set, q_set};
			gate <= gate_req;
			align <= align_req;
		end
	end
endmodule // qcr_src
`default_nettype wire

// File: quadrature_correction_regs_bench.sv
// Testbench: registers, sync selection and correction arithmetic.
// Assumes qcr_regs with the checker bound and qcr_src as sample source.
`timescale 1ns/100ps
`default_nettype none
module quadrature_correction_regs_bench;
	import qcr_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        gate_req, align_req, gate, align;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] i_set, q_set, cst;
	qcr_sample_t smp, out;
	int          n_mismatch, n_tests, ga, gb, ph, oa, ob, cen;
	qcr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .transmit_gate(gate), .align_strobe(align),
		.sample_in(smp), .converter_out(out));
	qcr_src u_src (.pclk(pclk), .presetn(presetn), .i_set(i_set), .q_set(q_set),
		.gate_req(gate_req), .align_req(align_req), .sample(smp), .gate(gate), .align(align));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_mismatch++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [11:0] i, logic [7:0] d);
		apb(1'b1, {i[9:0], 2'b00}, {24'h0, d});
	endtask
	task automatic pulse(logic g);
		@(posedge pclk);
		gate_req <= g;
		align_req <= !g;
		@(posedge pclk);
		gate_req <= 1'b0;
		align_req <= 1'b0;
	endtask
	function automatic logic [15:0] sat(longint v);
		return v > 32767 ? 16'h7fff : (v < -32768 ? 16'h8000 : v[15:0]);
	endfunction
	task automatic look(string nm, logic [15:0] iv, logic [15:0] qv);
		longint i, q;
		@(posedge pclk);
		i_set <= iv;
		q_set <= qv;
		repeat (6) @(posedge pclk);
		i = $signed(iv);
		q = $signed(qv);
		chk({nm, " i"}, out.i_data, cen ? cst : sat($signed(sat(((i * ga) >>> 10) +
			((q * ph) >>> 12))) + oa));
		chk({nm, " q"}, out.q_data, cen ? cst : sat($signed(sat((q * gb) >>> 10)) + ob));
		chk({nm, " valid"}, 32'(out.valid), 32'h1);
		$display("test %s done", nm);
	endtask
	task automatic t_regs();
		for (int k = 12; k <= 21; k++) begin
			apb(1'b0, 12'(k * 4), 32'h0);
			chk("reset value", rd, k == 15 ? 32'h24 : 32'h0);
			wr(12'(k), 8'hff);
			apb(1'b0, 12'(k * 4), 32'h0);
			chk("readback", rd, (k == 18 || k == 19) ? 32'hf8 : 32'hff);
			chk("no error", 32'(er), 32'h0);
			wr(12'(k), k == 15 ? 8'h24 : 8'h00);
		end
		apb(1'b0, 12'h004, 32'h0);
		chk("unmapped err", 32'(er), 32'h1);
		apb(1'b1, 12'h031, 32'h0);
		chk("misaligned err", 32'(er), 32'h1);
		$display("test regs done");
	endtask
	task automatic t_sync();
		look("unity", 16'd1000, -16'sd1600);
		wr(ADDR_UPPER_BITS, 8'h14);
		look("no load yet", 16'd1000, -16'sd1600);
		pulse(1'b1);
		look("gate ignored", 16'd1000, -16'sd1600);
		pulse(1'b0);
		ga = 512;
		look("align load", 16'd1000, -16'sd1600);
	endtask
	task automatic t_host();
		wr(ADDR_SYNC_CTRL, 8'h09);
		wr(ADDR_GAIN_B_LOW, 8'h80);
		wr(ADDR_UPPER_BITS, 8'h64);
		wr(ADDR_CONTROL, 8'h02);
		ga = 1024;
		gb = 1152;
		ph = 256;
		look("host load", 16'd1000, -16'sd1600);
		apb(1'b0, 12'h060, 32'h0);
		chk("sync seen", rd, 32'h3);
		apb(1'b1, 12'h060, 32'h0);
		apb(1'b0, 12'h060, 32'h0);
		chk("seen cleared", rd, 32'h0);
		wr(ADDR_SYNC_CTRL, 8'h08);
		wr(ADDR_OFFSET_A_LOW, 8'hfd);
		wr(ADDR_OFFSET_A_HI, 8'hf8);
		wr(ADDR_OFFSET_B_LOW, 8'hff);
		pulse(1'b0);
		look("ofs waits", 16'd1000, 16'd32700);
		pulse(1'b1);
		oa = -3;
		ob = 255;
		look("offset sat", 16'd1000, 16'd32700);
	endtask
	task automatic t_never();
		wr(ADDR_SYNC_CTRL, 8'h0f);
		wr(ADDR_GAIN_A_LOW, 8'h55);
		wr(ADDR_OFFSET_B_HI, 8'h80);
		pulse(1'b1);
		pulse(1'b0);
		wr(ADDR_CONTROL, 8'h02);
		look("never", -16'sd700, 16'd900);
		wr(ADDR_CONST_LOW, 8'h01);
		wr(ADDR_CONST_HIGH, 8'h80);
		wr(ADDR_CONTROL, 8'h01);
		cen = 1;
		look("constant", -16'sd700, 16'd900);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, gate_req, align_req} = '0;
		{paddr, pwdata, i_set, q_set} = '0;
		{ga, gb, ph, oa, ob, cen, n_mismatch, n_tests} = {32'd1024, 32'd1024, 192'd0};
		cst = 16'h8001;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_sync();
		t_host();
		t_never();
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		stop_test();
	end
endmodule // quadrature_correction_regs_bench
`default_nettype wire
